/* spi_enhanced_buffer_status.sv */
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`include "spi_enh_cfg.svh"
module spi_enhanced_buffer_status #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic chip_idle,
  input wire spi_enh_pkg::pin_in_type pins_in,
  output spi_enh_pkg::pin_out_type pins_out,
  output spi_enh_pkg::pin_out_type pins_oe,
  output logic irq
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int BW = $clog2(WIDTH);
  localparam logic [BW-1:0] LAST_BIT = BW'(WIDTH - 1);

  logic [1:0] rst_sync_r; // Reset release chain.
  logic rst_n; // Synchronised reset used by everything else.
  logic [2:0] meta_r, sync_r, hist_r; // Pin synchroniser and edge history.
  spi_enh_pkg::pin_in_type s_now, s_prev; // Clean pin levels now and one cycle ago.
  logic en_r, en_nxt, halt_r, halt_nxt; // Port enable and halt in idle.
  logic [2:0] sel_r, sel_nxt; // Interrupt condition select.
  logic master_r, master_nxt, enh_r, enh_nxt; // Master mode and enhanced buffering.
  logic [7:0] div_r, div_nxt; // Half period of the generated clock minus one.
  logic ovf_r, ovf_nxt; // Receive overflow flag.
  logic [`IRQ_BITS-1:0] ist_r, ist_nxt, ien_r, ien_nxt; // Interrupt status and enable.
  logic [15:0] rdata_r, rdata_nxt; // Read data, valid the cycle after a read.
  logic cond_q_r, cond; // Selected buffer condition and its previous value.
  spi_enh_pkg::eng_state_type state_r, state_nxt; // Shift engine state.
  logic [WIDTH-1:0] sh_r, sh_nxt; // Shift register.
  logic samp_r, samp_nxt; // Bit captured on the rising clock edge.
  logic [BW-1:0] bit_r, bit_nxt; // Bits shifted in this word.
  logic [7:0] divc_r, divc_nxt; // Master clock divider.
  logic sck_r, sck_nxt, ss_r, ss_nxt; // Master clock and select outputs.
  logic run, rise, fall; // Engine allowed to move and clock edges.
  logic tx_push, tx_pop, rx_push, rx_pop, rx_keep; // FIFO strobes.
  logic [WIDTH-1:0] tx_dout, rx_dout, rx_word; // FIFO data.
  logic [CW-1:0] tx_count, rx_count, limit; // FIFO fill and usable depth.
  logic tx_full, rx_full, rx_empty; // FIFO levels.
  logic [2:0] elem_count; // Reported element count.
  logic [15:0] stat_word; // Assembled status and control word.
  logic clr_ovf; // Software clears the overflow flag.

  // Reset is asserted at once and released two clock edges later.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // Each pin lane passes two flip-flops; a third keeps history for edge finding.
  for (genvar i = 0; i < 3; i++)
  begin : g_sync
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        meta_r[i] <= 1'b1;
        sync_r[i] <= 1'b1;
        hist_r[i] <= 1'b1;
      end
      else
      begin
        meta_r[i] <= pins_in[i];
        sync_r[i] <= meta_r[i];
        hist_r[i] <= sync_r[i];
      end
    end
  end
  assign s_now = sync_r;
  assign s_prev = hist_r;

  // In non-enhanced mode each direction behaves as a single buffer word.
  assign limit = enh_r ? CW'(DEPTH) : CW'(1);
  assign tx_full = tx_count >= limit;
  assign rx_full = rx_count >= limit;
  assign rx_empty = (rx_count == '0);

  // Transmit and receive stores; disabling the port flushes both.
  spi_word_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_tx (
    .clk(clk), .rst_n(rst_n), .clear(!en_r), .push(tx_push), .din(wdata[WIDTH-1:0]),
    .pop(tx_pop), .dout(tx_dout), .count(tx_count)
  );
  spi_word_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_rx (
    .clk(clk), .rst_n(rst_n), .clear(!en_r), .push(rx_keep), .din(rx_word),
    .pop(rx_pop), .dout(rx_dout), .count(rx_count)
  );

  assign run = en_r && !(halt_r && chip_idle);

  // Shift engine: master makes the clock by a divider, slave follows the pins.
  always_comb
  begin
    state_nxt = state_r;
    sh_nxt = sh_r;
    samp_nxt = samp_r;
    bit_nxt = bit_r;
    divc_nxt = divc_r;
    sck_nxt = sck_r;
    ss_nxt = ss_r;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_word = {sh_r[WIDTH-2:0], samp_r};
    rise = 1'b0;
    fall = 1'b0;
    if (!en_r)
    begin
      state_nxt = spi_enh_pkg::ENG_IDLE;
      sh_nxt = '0;
      bit_nxt = '0;
      sck_nxt = 1'b0;
      ss_nxt = 1'b1;
    end
    else if (run)
    begin
      case (state_r)
        spi_enh_pkg::ENG_IDLE:
        begin
          // A master starts only with data queued; a slave starts on select.
          if (master_r ? (tx_count != '0) : !s_now.ss_n)
          begin
            state_nxt = spi_enh_pkg::ENG_ACTIVE;
            sh_nxt = (tx_count != '0) ? tx_dout : '0;
            tx_pop = (tx_count != '0);
            bit_nxt = '0;
            divc_nxt = div_r;
            sck_nxt = 1'b0;
            ss_nxt = !master_r;
          end
        end
        spi_enh_pkg::ENG_ACTIVE:
        begin
          if (master_r)
          begin
            if (divc_r == 8'h00)
            begin
              divc_nxt = div_r;
              sck_nxt = !sck_r;
              rise = !sck_r;
              fall = sck_r;
            end
            else
              divc_nxt = divc_r - 8'h01;
          end
          else
          begin
            rise = s_now.sck && !s_prev.sck;
            fall = !s_now.sck && s_prev.sck;
          end
          if (!master_r && s_now.ss_n)
            state_nxt = spi_enh_pkg::ENG_IDLE; // Deselect aborts a partial word.
          else if (rise)
            samp_nxt = s_now.sdi;
          else if (fall)
          begin
            sh_nxt = {sh_r[WIDTH-2:0], samp_r};
            bit_nxt = bit_r + BW'(1);
            if (bit_r == LAST_BIT)
            begin
              rx_push = 1'b1;
              bit_nxt = '0;
              if (tx_count != '0)
              begin
                sh_nxt = tx_dout;
                tx_pop = 1'b1;
              end
              else if (master_r)
              begin
                state_nxt = spi_enh_pkg::ENG_IDLE;
                ss_nxt = 1'b1;
              end
              else
                sh_nxt = '0; // Slave with nothing queued shifts out zeros.
            end
          end
        end
        default:
          state_nxt = spi_enh_pkg::ENG_IDLE;
      endcase
    end
  end

  // Shift engine registers.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= spi_enh_pkg::ENG_IDLE;
      sh_r <= '0;
      samp_r <= 1'b0;
      bit_r <= '0;
      divc_r <= 8'h00;
      sck_r <= 1'b0;
      ss_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      sh_r <= sh_nxt;
      samp_r <= samp_nxt;
      bit_r <= bit_nxt;
      divc_r <= divc_nxt;
      sck_r <= sck_nxt;
      ss_r <= ss_nxt;
    end
  end

  assign pins_out = {sck_r, sh_r[WIDTH-1], ss_r};
  assign pins_oe.sck = en_r && master_r;
  assign pins_oe.ss_n = en_r && master_r;
  assign pins_oe.sdo = en_r && (master_r || !s_now.ss_n);

  assign rx_keep = rx_push && !rx_full;

  always_comb
  begin
    elem_count = 3'h0;
    if (master_r)
      elem_count = (int'(tx_count) > `CNT_MAX) ? 3'h7 : 3'(tx_count);
    else
      elem_count = (int'(rx_count) > `CNT_MAX) ? 3'h7 : 3'(rx_count);
  end

  // unused bits zero, enhanced fields gated
  always_comb
  begin
    stat_word = 16'h0000;
    stat_word[`STAT_EN_BIT] = en_r;
    stat_word[`STAT_HALT_BIT] = halt_r;
    stat_word[`STAT_CNT_MSB:`STAT_CNT_LSB] = enh_r ? elem_count : 3'h0;
    stat_word[`STAT_SHE_BIT] = enh_r && (state_r == spi_enh_pkg::ENG_IDLE);
    stat_word[`STAT_OVF_BIT] = ovf_r;
    stat_word[`STAT_RXE_BIT] = enh_r && rx_empty;
    stat_word[`STAT_SEL_MSB:`STAT_SEL_LSB] = sel_r;
    stat_word[`STAT_TXF_BIT] = tx_full;
    stat_word[`STAT_RXF_BIT] = !rx_empty && rx_full;
  end

  // buffer condition for each selector code, transmit and receive
  always_comb
  begin
    case (sel_r)
      `SEL_TX_FULL: cond = tx_full;
      `SEL_TX_LAST_IN: cond = tx_pop && (tx_count == CW'(1));
      `SEL_TX_DONE: cond = (state_r == spi_enh_pkg::ENG_IDLE) && (tx_count == '0);
      `SEL_TX_SPOT: cond = tx_pop;
      `SEL_RX_FULL: cond = rx_full;
      `SEL_RX_3Q: cond = !rx_empty &&
        (int'(rx_count) * `THREEQ_DEN >= DEPTH * `THREEQ_NUM);
      `SEL_RX_AVAIL: cond = !rx_empty;
      `SEL_RX_READ_EMPTY: cond = rx_empty;
      default: cond = 1'b0;
    endcase
  end

  // Register port: writes take effect at once, reads answer one cycle later.
  always_comb
  begin
    en_nxt = en_r;
    halt_nxt = halt_r;
    sel_nxt = sel_r;
    master_nxt = master_r;
    enh_nxt = enh_r;
    div_nxt = div_r;
    ien_nxt = ien_r;
    rdata_nxt = rdata_r;
    tx_push = 1'b0;
    rx_pop = 1'b0;
    clr_ovf = 1'b0;
    ist_nxt = ist_r;
    if (wr)
    begin
      case (addr)
        `REG_STAT:
        begin
          en_nxt = wdata[`STAT_EN_BIT];
          halt_nxt = wdata[`STAT_HALT_BIT];
          sel_nxt = wdata[`STAT_SEL_MSB:`STAT_SEL_LSB];
          clr_ovf = !wdata[`STAT_OVF_BIT];
        end
        `REG_DATA: tx_push = en_r && !tx_full; // A write to a full buffer is lost.
        `REG_CFG:
        begin
          master_nxt = wdata[`CFG_MASTER_BIT];
          enh_nxt = wdata[`CFG_ENH_BIT];
          div_nxt = wdata[`CFG_DIV_MSB:`CFG_DIV_LSB];
        end
        `REG_ICLR: ist_nxt = ist_r & ~wdata[`IRQ_BITS-1:0];
        `REG_IEN: ien_nxt = wdata[`IRQ_BITS-1:0];
        default: ;
      endcase
    end
    if (rd)
    begin
      case (addr)
        `REG_STAT: rdata_nxt = stat_word;
        `REG_DATA:
        begin
          rdata_nxt = 16'(rx_dout);
          rx_pop = !rx_empty;
        end
        `REG_CFG: rdata_nxt = {div_r, 6'h00, enh_r, master_r};
        `REG_ISTAT: rdata_nxt = 16'(ist_r);
        `REG_IEN: rdata_nxt = 16'(ien_r);
        default: rdata_nxt = 16'h0000; // Unmapped and write-only addresses read zero.
      endcase
    end
    ovf_nxt = (rx_push && rx_full) || (ovf_r && !clr_ovf);
    // Events set their sticky bit even in the cycle software clears it.
    if (en_r && cond && !cond_q_r)
      ist_nxt[`IRQ_BUF_BIT] = 1'b1;
    if (rx_push && rx_full)
      ist_nxt[`IRQ_OVF_BIT] = 1'b1;
  end

  // Register file.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_r <= 1'b0;
      halt_r <= 1'b0;
      sel_r <= 3'h0;
      master_r <= 1'b0;
      enh_r <= 1'b0;
      div_r <= `CFG_DIV_RESET;
      ovf_r <= 1'b0;
      ist_r <= '0;
      ien_r <= '0;
      rdata_r <= 16'h0000;
      cond_q_r <= 1'b1; // Starts high so reset does not look like an event.
    end
    else
    begin
      en_r <= en_nxt;
      halt_r <= halt_nxt;
      sel_r <= sel_nxt;
      master_r <= master_nxt;
      enh_r <= enh_nxt;
      div_r <= div_nxt;
      ovf_r <= ovf_nxt;
      ist_r <= ist_nxt;
      ien_r <= ien_nxt;
      rdata_r <= rdata_nxt;
      cond_q_r <= cond;
    end
  end

  assign rdata = rdata_r;
  assign irq = |(ist_r & ien_r);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  disabled_pins_a: assert property (
    !en_r |-> ##1 (!en_r |-> pins_oe == 3'h0 && state_r == spi_enh_pkg::ENG_IDLE))
    else $error("Port acts while disabled.");
  idle_freeze_a: assert property (
    en_r && halt_r && chip_idle && !wr |=> $stable(sh_r) && $stable(bit_r))
    else $error("Shifter moved while halted in idle.");
  master_count_a: assert property (
    enh_r && master_r && tx_push && !tx_pop && tx_count < CW'(3)
    |=> stat_word[`STAT_CNT_MSB:`STAT_CNT_LSB] == $past(elem_count) + 3'h1)
    else $error("Pending count did not follow a queued write.");
  slave_count_a: assert property (
    enh_r && !master_r && rx_keep && !rx_pop && rx_count < CW'(3) && !wr
    |=> stat_word[`STAT_CNT_MSB:`STAT_CNT_LSB] == $past(elem_count) + 3'h1)
    else $error("Unread count did not follow a received word.");
  shifter_flag_a: assert property (
    enh_r && run && master_r && state_r == spi_enh_pkg::ENG_IDLE && tx_count != '0 && !wr
    |=> !stat_word[`STAT_SHE_BIT])
    else $error("Shifter reported empty after loading.");
  overflow_set_a: assert property (
    rx_push && rx_full && !rx_pop |=> ovf_r && $stable(rx_count))
    else $error("Overflow not flagged or word not discarded.");
  rx_empty_a: assert property (
    enh_r && rx_pop && rx_count == CW'(1) && !rx_push && !wr
    |=> stat_word[`STAT_RXE_BIT])
    else $error("Receive empty flag missing after last read.");
  sel_txdone_a: assert property (
    en_r && sel_r == `SEL_TX_DONE && state_r == spi_enh_pkg::ENG_ACTIVE && tx_count == '0 &&
    state_nxt == spi_enh_pkg::ENG_IDLE && !wr |=> ##1 ist_r[`IRQ_BUF_BIT])
    else $error("No interrupt at end of transmission.");
  sel_rxfull_a: assert property (
    en_r && sel_r == `SEL_RX_FULL && $stable(sel_r) && $rose(rx_full)
    |=> ist_r[`IRQ_BUF_BIT])
    else $error("No interrupt on receive full.");
  sel_rxread_a: assert property (
    en_r && sel_r == `SEL_RX_READ_EMPTY && $stable(sel_r) && $rose(rx_empty)
    |=> ist_r[`IRQ_BUF_BIT])
    else $error("No interrupt when last word read.");
  enh_off_zero_a: assert property (
    !enh_r |-> stat_word[`STAT_CNT_MSB:`STAT_CNT_LSB] == 3'h0 &&
    !stat_word[`STAT_SHE_BIT] && !stat_word[`STAT_RXE_BIT] && stat_word[14] == 1'b0)
    else $error("Enhanced fields not zero while enhanced mode off.");
endmodule

/* spi_enh_cfg.svh */
`ifndef SPI_ENH_CFG_SVH
`define SPI_ENH_CFG_SVH
// Register indices on the software port.
`define REG_STAT 3'h0
`define REG_DATA 3'h1
`define REG_CFG 3'h2
`define REG_ISTAT 3'h3
`define REG_ICLR 3'h4
`define REG_IEN 3'h5
// Field positions of the status and control register.
`define STAT_EN_BIT 15
`define STAT_HALT_BIT 13
`define STAT_CNT_MSB 10
`define STAT_CNT_LSB 8
`define STAT_SHE_BIT 7
`define STAT_OVF_BIT 6
`define STAT_RXE_BIT 5
`define STAT_SEL_MSB 4
`define STAT_SEL_LSB 2
`define STAT_TXF_BIT 1
`define STAT_RXF_BIT 0
// Field positions and reset values of the configuration register.
`define CFG_MASTER_BIT 0
`define CFG_ENH_BIT 1
`define CFG_DIV_MSB 15
`define CFG_DIV_LSB 8
`define CFG_DIV_RESET 8'h03
// Interrupt condition selector codes.
`define SEL_RX_READ_EMPTY 3'h0
`define SEL_RX_AVAIL 3'h1
`define SEL_RX_3Q 3'h2
`define SEL_RX_FULL 3'h3
`define SEL_TX_SPOT 3'h4
`define SEL_TX_DONE 3'h5
`define SEL_TX_LAST_IN 3'h6
`define SEL_TX_FULL 3'h7
// Interrupt status bit positions and width.
`define IRQ_BUF_BIT 0
`define IRQ_OVF_BIT 1
`define IRQ_BITS 2
// Element count saturation and the three-quarter threshold.
`define CNT_MAX 7
`define THREEQ_NUM 3
`define THREEQ_DEN 4
`endif

/* spi_enh_pkg.sv */
package spi_enh_pkg;
  // Shift engine state.
  typedef enum logic {ENG_IDLE, ENG_ACTIVE} eng_state_type;
  // Serial pins driven by the port.
  typedef struct packed {
    logic sck;
    logic sdo;
    logic ss_n;
  } pin_out_type;
  // Serial pins seen by the port.
  typedef struct packed {
    logic sck;
    logic sdi;
    logic ss_n;
  } pin_in_type;
endpackage

/* spi_word_fifo.sv */
`timescale 1ns/100ps
module spi_word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic push,
  input wire logic [WIDTH-1:0] din,
  input wire logic pop,
  output logic [WIDTH-1:0] dout,
  output logic [CW-1:0] count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic do_push, do_pop;

  // Pushes into a full store and pops from an empty one are dropped here as well.
  always_comb
  begin
    do_push = push && (cnt_r < CW'(DEPTH));
    do_pop = pop && (cnt_r != '0);
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (clear)
    begin
      wr_nxt = '0;
      rd_nxt = '0;
      cnt_nxt = '0;
    end
    else
    begin
      if (do_push)
        wr_nxt = (wr_r == LAST) ? '0 : wr_r + AW'(1);
      if (do_pop)
        rd_nxt = (rd_r == LAST) ? '0 : rd_r + AW'(1);
      cnt_nxt = cnt_r + CW'(do_push) - CW'(do_pop);
    end
  end

  // Pointer and count registers.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // The storage holds data only, so it needs no reset.
  always_ff @(posedge clk)
  begin
    if (do_push && !clear)
      mem[wr_r] <= din;
  end

  assign dout = mem[rd_r];
  assign count = cnt_r;
endmodule

/* spi_peer_model.sv */
`timescale 1ns/100ps
// Behavioural far-side peer. It answers as a slave while the port is master,
// and plays master through send_byte while the port is a slave.
module spi_peer_model (
  input wire spi_enh_pkg::pin_out_type dut_out,
  output spi_enh_pkg::pin_in_type to_dut,
  input wire logic [7:0] reply,
  output logic [7:0] heard,
  output int words
);
  // Peer clock stands low outside frames; the select idles high.
  logic m_sck = 1'b0;
  logic m_ss_n = 1'b1;
  logic sdi_r = 1'b1;
  logic [7:0] sh_r = 8'h00;
  int nb = 0;
  initial heard = 8'h00;
  initial words = 0;
  assign to_dut.sck = m_sck;
  assign to_dut.ss_n = m_ss_n;
  assign to_dut.sdi = sdi_r;
  // Selected by the port: the reply goes out MSB first.
  always @(negedge dut_out.ss_n)
  begin
    nb = 0;
    sh_r = reply;
    sdi_r = reply[7];
  end
  // Released: show the inverse so a stale level is never mistaken for data.
  always @(posedge dut_out.ss_n)
    sdi_r = ~sdi_r;
  // Capture on the rising serial edge and count whole words.
  always @(posedge dut_out.sck)
    if (m_ss_n && !dut_out.ss_n)
    begin
      heard = {heard[6:0], dut_out.sdo};
      nb = nb + 1;
      if (nb == 8)
      begin
        nb = 0;
        words = words + 1;
      end
    end
  // Shift on the falling edge, reloading for back-to-back words.
  always @(negedge dut_out.sck)
    if (m_ss_n && !dut_out.ss_n)
    begin
      sh_r = (nb == 0) ? reply : {sh_r[6:0], 1'b0};
      sdi_r = sh_r[7];
    end
  // Master role: a 160 ns serial clock, select low well before the first edge.
  task automatic send_byte(input logic [7:0] b);
    m_ss_n = 1'b0;
    #100;
    for (int i = 7; i >= 0; i--)
    begin
      sdi_r = b[i];
      #80 m_sck = 1'b1;
      heard = {heard[6:0], dut_out.sdo};
      #80 m_sck = 1'b0;
    end
    #100 m_ss_n = 1'b1;
    sdi_r = ~sdi_r;
    words = words + 1;
    // Keep the select high long enough that the port sees a real frame gap.
    #160;
  endtask
endmodule

/* spi_enhanced_buffer_status_tb_top.sv */
`timescale 1ns/100ps
`include "spi_enh_cfg.svh"
// Self-checking bench: register port on one side, behavioural peer on the other.
module spi_enhanced_buffer_status_tb_top;
  logic clk;
  logic arst_n;
  logic [2:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic chip_idle;
  logic irq;
  logic [7:0] reply;
  logic [7:0] heard;
  logic [7:0] b [0:4];
  logic [15:0] got;
  int words;
  int err_total = 0;
  int num_checks = 0;
  spi_enh_pkg::pin_in_type pins_in;
  spi_enh_pkg::pin_out_type pins_out;
  spi_enh_pkg::pin_out_type pins_oe;

  spi_enhanced_buffer_status #(.DEPTH(4), .WIDTH(8)) dut_u (.clk(clk), .arst_n(arst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .chip_idle(chip_idle),
    .pins_in(pins_in), .pins_out(pins_out), .pins_oe(pins_oe), .irq(irq));
  spi_peer_model peer_u (.dut_out(pins_out), .to_dut(pins_in), .reply(reply),
    .heard(heard), .words(words));

  // Free-running 50 MHz clock.
  always #10 clk = ~clk;

  // Expected status word assembled field by field; unused bits are zero.
  function automatic logic [15:0] stat_v(input logic en, input logic [2:0] cnt,
    input logic she, input logic ovf, input logic rxe, input logic [2:0] sel,
    input logic rxf);
    return {en, 1'b0, 1'b1, 2'b00, cnt, she, ovf, rxe, sel, 1'b0, rxf};
  endfunction

  // One comparison, counted, reporting at once on a difference.
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
    end
  endtask

  // Single-cycle register write.
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Let the write settle so that checks made straight after see its effect.
    #1;
  endtask

  // Single-cycle read; data is taken in the first cycle where it stands.
  task automatic rd_chk(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask

  // Bounded wait for the peer to count words, then 16 cycles, two serial periods at divider 3, for the push.
  task automatic wait_words(input int n);
    for (int k = 0; k < 3000 && words < n; k++)
      @(posedge clk);
    chk(16'(words >= n), 16'h0001);
    repeat (16) @(posedge clk);
  endtask

  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // A hang counts as a mismatch and ends the run the same way.
  initial
  begin
    repeat (30000) @(posedge clk);
    err_total++;
    stop_test();
  end

  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    addr = 3'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    chip_idle = 1'b0;
    void'($urandom(32'h99f1));
    reply = 8'($urandom);
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(`REG_STAT, 16'h0000);
    rd_chk(3'h6, 16'h0000);
    chk(16'(pins_oe), 16'h0000);
    // Master, enhanced, divider 3; frozen in idle while the queue fills.
    wr_reg(`REG_CFG, 16'h0303);
    wr_reg(`REG_IEN, 16'h0003);
    chip_idle <= 1'b1;
    wr_reg(`REG_STAT, 16'ha054);
    for (int i = 0; i < 3; i++)
    begin
      b[i] = 8'($urandom);
      wr_reg(`REG_DATA, {8'h00, b[i]});
    end
    repeat (40) @(posedge clk);
    rd_chk(`REG_STAT, stat_v(1, 3, 1, 0, 1, 5, 0));
    chk(16'(pins_oe), 16'h0007);
    chip_idle <= 1'b0;
    wait_words(3);
    chk({8'h00, heard}, {8'h00, b[2]});
    rd_chk(`REG_STAT, stat_v(1, 0, 1, 0, 0, 5, 0));
    chk(16'(irq), 16'h0001);
    wr_reg(`REG_IEN, 16'h0000);
    chk(16'(irq), 16'h0000);
    wr_reg(`REG_IEN, 16'h0003);
    wr_reg(`REG_ICLR, 16'h0003);
    chk(16'(irq), 16'h0000);
    // Drain with the last-read selector; the final read must raise the event.
    wr_reg(`REG_STAT, 16'ha040);
    for (int i = 0; i < 3; i++)
      rd_chk(`REG_DATA, {8'h00, reply});
    rd_chk(`REG_STAT, stat_v(1, 0, 1, 0, 1, 0, 0));
    rd_chk(`REG_ISTAT, 16'h0001);
    // Fill the receive side, then overrun it with a distinct reply.
    wr_reg(`REG_ICLR, 16'h0003);
    wr_reg(`REG_STAT, 16'ha04c);
    for (int i = 0; i < 4; i++)
      wr_reg(`REG_DATA, 16'(8'($urandom)));
    wait_words(7);
    rd_chk(`REG_ISTAT, 16'h0001);
    reply = ~reply;
    wr_reg(`REG_DATA, 16'h00a5);
    wait_words(8);
    rd_chk(`REG_STAT, stat_v(1, 0, 1, 1, 0, 3, 1));
    rd_chk(`REG_ISTAT, 16'h0003);
    wr_reg(`REG_STAT, 16'ha00c);
    rd_chk(`REG_STAT, stat_v(1, 0, 1, 0, 0, 3, 1));
    for (int i = 0; i < 4; i++)
      rd_chk(`REG_DATA, {8'h00, ~reply});
    rd_chk(`REG_STAT, stat_v(1, 0, 1, 0, 1, 3, 0));
    // Disabled port releases its pins; plain buffering hides enhanced fields.
    wr_reg(`REG_STAT, 16'h2000);
    chk(16'(pins_oe), 16'h0000);
    wr_reg(`REG_CFG, 16'h0301);
    wr_reg(`REG_STAT, 16'ha004);
    rd_chk(`REG_STAT, stat_v(1, 0, 0, 0, 0, 1, 0));
    // Slave, enhanced, data-available selector: the peer clocks in two words at 160 ns.
    wr_reg(`REG_CFG, 16'h0302);
    wr_reg(`REG_ICLR, 16'h0003);
    for (int i = 3; i < 5; i++)
    begin
      b[i] = 8'($urandom);
      peer_u.send_byte(b[i]);
    end
    repeat (10) @(posedge clk);
    rd_chk(`REG_STAT, stat_v(1, 2, 1, 0, 0, 1, 0));
    rd_chk(`REG_ISTAT, 16'h0001);
    rd_chk(`REG_DATA, {8'h00, b[3]});
    rd_chk(`REG_DATA, {8'h00, b[4]});
    rd_chk(`REG_STAT, stat_v(1, 0, 1, 0, 1, 1, 0));
    stop_test();
  end
endmodule
